// ### verilog/ldt_pkg.sv
// Purpose: constants and carrier types for the level alarm threshold logic
// Assumes: one sample clock, registers written through the internal serial-port register port
// Notes: offsets are the byte addresses of the serial control map
// Notes on behaviour
// - upper threshold: low byte plus nibble
// - lower threshold: low byte plus nibble
// - compare thresholds against corrected sample magnitude
// - dwell target: high byte above low
// - release alarm after dwell below lower
// - all threshold and dwell registers reset zero
// - detection runs only while enabled
// - force bit drives force value out
`default_nettype none
package ldt_pkg;
  localparam int ADDR_W = 8;
  localparam int REG_W = 8;
  localparam int SAMPLE_W = 12;
  localparam int DWELL_W = 16;

  localparam logic [7:0] CTRL_OFS = 8'h45;
  localparam logic [7:0] UPPER_LOW_OFS = 8'h47;
  localparam logic [7:0] UPPER_HIGH_OFS = 8'h48;
  localparam logic [7:0] LOWER_LOW_OFS = 8'h49;
  localparam logic [7:0] LOWER_HIGH_OFS = 8'h4A;
  localparam logic [7:0] DWELL_LOW_OFS = 8'h4B;
  localparam logic [7:0] DWELL_HIGH_OFS = 8'h4C;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FORCE_VALUE_BIT = 2;
  localparam int CTRL_FORCE_BIT = 3;
  localparam logic [7:0] CTRL_MASK = 8'h0D;
  localparam logic [7:0] NIBBLE_MASK = 8'h0F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } ldt_sample_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata;
  } ldt_reg_req_type;

  typedef enum logic [1:0] {
    LDT_CLEAR = 2'b01,
    LDT_ALARM = 2'b10
  } ldt_state_type;
endpackage
`default_nettype wire

// ### verilog/ldt_dwell_counter.sv
// Purpose: counts consecutive below-threshold samples against a target
// Assumes: clr and inc are never both needed; clr wins
// Notes: saturates at all ones so a huge target never wraps
`timescale 1ns/1ps
`default_nettype none
module ldt_dwell_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic inc,
  input wire logic [WIDTH-1:0] target,
  output logic done
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic [WIDTH:0] bumped;

  if (WIDTH < 1) begin : g_width_check
    $error("ldt_dwell_counter: WIDTH must be at least 1");
  end

  always_comb begin
    bumped = {1'b0, count} + {{WIDTH{1'b0}}, 1'b1};
    // a zero target releases on the first quiet sample, like a target of one
    done = inc && (bumped >= {1'b0, target});
    next_count = count;
    if (clr || done) begin
      next_count = '0;
    end else if (inc && !bumped[WIDTH]) begin
      next_count = bumped[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// ### verilog/ldt_level_alarm.sv
// Purpose: level alarm on the corrected converter sample magnitude
// Assumes: samples and register requests are synchronous to CLK
// Notes: pin changes at the edge that takes the deciding sample
`timescale 1ns/1ps
`default_nettype none
module ldt_level_alarm #(
  parameter int SAMPLE_BITS = ldt_pkg::SAMPLE_W,
  parameter int DWELL_BITS = ldt_pkg::DWELL_W
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire ldt_pkg::ldt_sample_type SAMPLE,
  input wire ldt_pkg::ldt_reg_req_type REG,
  output logic [ldt_pkg::REG_W-1:0] REG_RDATA,
  output logic LEVEL_ALARM_OUT
);
  import ldt_pkg::*;

  if (SAMPLE_BITS != SAMPLE_W || DWELL_BITS != DWELL_W) begin : g_width_check
    $error("ldt_level_alarm: widths are fixed by the register layout");
  end

  logic [7:0] ctrl;
  logic [7:0] upper_threshold_low;
  logic [7:0] upper_threshold_high;
  logic [7:0] lower_threshold_low;
  logic [7:0] lower_threshold_high;
  logic [7:0] dwell_target_low;
  logic [7:0] dwell_target_high;
  logic [7:0] next_ctrl;
  logic [7:0] next_upper_threshold_low;
  logic [7:0] next_upper_threshold_high;
  logic [7:0] next_lower_threshold_low;
  logic [7:0] next_lower_threshold_high;
  logic [7:0] next_dwell_target_low;
  logic [7:0] next_dwell_target_high;
  logic [7:0] next_rdata;

  ldt_state_type state;
  ldt_state_type next_state;
  logic next_pin;

  logic [SAMPLE_W-1:0] upper_threshold;
  logic [SAMPLE_W-1:0] lower_threshold;
  logic [DWELL_W-1:0] dwell_target;
  logic [SAMPLE_W-1:0] magnitude;
  logic enable;
  logic above_upper;
  logic below_lower;
  logic dwell_clr;
  logic dwell_inc;
  logic dwell_done;

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  // two's complement magnitude; the most negative code gives 2048, which still fits
  function automatic logic [SAMPLE_W-1:0] magnitude_of(input logic [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] neg;
    neg = '0;
    neg = ~s + {{(SAMPLE_W-1){1'b0}}, 1'b1};
    magnitude_of = s[SAMPLE_W-1] ? neg : s;
  endfunction

  assign upper_threshold = {upper_threshold_high[3:0], upper_threshold_low};
  assign lower_threshold = {lower_threshold_high[3:0], lower_threshold_low};
  assign dwell_target = {dwell_target_high, dwell_target_low};
  assign enable = ctrl[CTRL_ENABLE_BIT];

  always_comb begin
    magnitude = magnitude_of(SAMPLE.data);
    above_upper = magnitude > upper_threshold;
    below_lower = magnitude < lower_threshold;
  end

  always_comb begin
    next_ctrl = ctrl;
    next_upper_threshold_low = upper_threshold_low;
    next_upper_threshold_high = upper_threshold_high;
    next_lower_threshold_low = lower_threshold_low;
    next_lower_threshold_high = lower_threshold_high;
    next_dwell_target_low = dwell_target_low;
    next_dwell_target_high = dwell_target_high;
    if (REG.wr) begin
      if (hit(REG.addr, CTRL_OFS)) begin
        next_ctrl = REG.wdata & CTRL_MASK;
      end
      if (hit(REG.addr, UPPER_LOW_OFS)) begin
        next_upper_threshold_low = REG.wdata;
      end
      if (hit(REG.addr, UPPER_HIGH_OFS)) begin
        next_upper_threshold_high = REG.wdata & NIBBLE_MASK;
      end
      if (hit(REG.addr, LOWER_LOW_OFS)) begin
        next_lower_threshold_low = REG.wdata;
      end
      if (hit(REG.addr, LOWER_HIGH_OFS)) begin
        next_lower_threshold_high = REG.wdata & NIBBLE_MASK;
      end
      if (hit(REG.addr, DWELL_LOW_OFS)) begin
        next_dwell_target_low = REG.wdata;
      end
      if (hit(REG.addr, DWELL_HIGH_OFS)) begin
        next_dwell_target_high = REG.wdata;
      end
    end
  end

  always_comb begin
    next_rdata = REG_RDATA;
    if (REG.rd) begin
      case (REG.addr)
        CTRL_OFS: begin
          next_rdata = ctrl;
        end
        UPPER_LOW_OFS: begin
          next_rdata = upper_threshold_low;
        end
        UPPER_HIGH_OFS: begin
          next_rdata = upper_threshold_high;
        end
        LOWER_LOW_OFS: begin
          next_rdata = lower_threshold_low;
        end
        LOWER_HIGH_OFS: begin
          next_rdata = lower_threshold_high;
        end
        DWELL_LOW_OFS: begin
          next_rdata = dwell_target_low;
        end
        DWELL_HIGH_OFS: begin
          next_rdata = dwell_target_high;
        end
        default: begin
          next_rdata = READ_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= REG_RESET;
      upper_threshold_low <= REG_RESET;
      upper_threshold_high <= REG_RESET;
      lower_threshold_low <= REG_RESET;
      lower_threshold_high <= REG_RESET;
      dwell_target_low <= REG_RESET;
      dwell_target_high <= REG_RESET;
      REG_RDATA <= REG_RESET;
    end else begin
      ctrl <= next_ctrl;
      upper_threshold_low <= next_upper_threshold_low;
      upper_threshold_high <= next_upper_threshold_high;
      lower_threshold_low <= next_lower_threshold_low;
      lower_threshold_high <= next_lower_threshold_high;
      dwell_target_low <= next_dwell_target_low;
      dwell_target_high <= next_dwell_target_high;
      REG_RDATA <= next_rdata;
    end
  end

  always_comb begin
    next_state = state;
    dwell_clr = 1'b0;
    dwell_inc = 1'b0;
    if (!enable) begin
      next_state = LDT_CLEAR;
      dwell_clr = 1'b1;
    end else if (SAMPLE.valid) begin
      case (state)
        LDT_CLEAR: begin
          dwell_clr = 1'b1;
          if (above_upper) begin
            next_state = LDT_ALARM;
          end
        end
        LDT_ALARM: begin
          if (!below_lower) begin
            dwell_clr = 1'b1;
          end else begin
            dwell_inc = 1'b1;
          end
          if (dwell_done) begin
            next_state = LDT_CLEAR;
          end
        end
        default: begin
          next_state = LDT_CLEAR;
          dwell_clr = 1'b1;
        end
      endcase
    end
    if (ctrl[CTRL_FORCE_BIT]) begin
      next_pin = ctrl[CTRL_FORCE_VALUE_BIT];
    end else begin
      next_pin = (next_state == LDT_ALARM);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= LDT_CLEAR;
      LEVEL_ALARM_OUT <= 1'b0;
    end else begin
      state <= next_state;
      LEVEL_ALARM_OUT <= next_pin;
    end
  end

  ldt_dwell_counter #(
    .WIDTH(DWELL_W)
  ) u_dwell (
    .clk(CLK),
    .rst_n(RST_N),
    .clr(dwell_clr),
    .inc(dwell_inc),
    .target(dwell_target),
    .done(dwell_done)
  );
endmodule
`default_nettype wire

// ### sim/ldt_level_alarm_sva.sv
// Purpose: port checker for the level alarm
// Assumes: registers shadowed from the write strobe
// Notes: release is checked against a lower bound on the run
`timescale 1ns/1ps
`default_nettype none
module ldt_level_alarm_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire ldt_pkg::ldt_sample_type SAMPLE,
  input wire ldt_pkg::ldt_reg_req_type REG,
  input wire logic [7:0] REG_RDATA,
  input wire logic LEVEL_ALARM_OUT
);
  import ldt_pkg::*;
  logic [7:0] s [8];
  logic [15:0] run;
  logic [12:0] mag;
  logic on, frc;
  assign mag = SAMPLE.data[11] ? 13'h1000 - {1'b0, SAMPLE.data} : {1'b0, SAMPLE.data};
  assign on = s[0][0];
  assign frc = s[0][3];
  // run may exceed the device count, so it only bounds the release from below
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '{default: 8'h00};
      run <= 16'h0000;
    end else begin
      if (REG.wr && REG.addr >= 8'h45 && REG.addr <= 8'h4C) begin
        s[REG.addr[2:0] - 3'h5] <= REG.wdata;
      end
      if (!on) begin
        run <= 16'h0000;
      end else if (SAMPLE.valid) begin
        run <= (mag < {1'b0, s[5][3:0], s[4]}) ? run + 16'h0001 : 16'h0000;
      end
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_up;
    REG.rd && !REG.wr && REG.addr == 8'h48 |=> REG_RDATA == {4'h0, s[3][3:0]};
  endproperty
  a_up: assert property (p_up) else $error("upper nibble");
  property p_lo;
    REG.rd && !REG.wr && REG.addr == 8'h4A |=> REG_RDATA == {4'h0, s[5][3:0]};
  endproperty
  a_lo: assert property (p_lo) else $error("lower nibble");
  property p_dw;
    REG.rd && !REG.wr && REG.addr == 8'h4C |=> REG_RDATA == s[7];
  endproperty
  a_dw: assert property (p_dw) else $error("dwell high");
  property p_rel;
    // the pin sampled now was set from the control sampled one edge earlier
    $fell(LEVEL_ALARM_OUT) && $past(on) && !$past(frc) && !$past(frc, 2)
      |-> run != 16'h0000 && run >= {s[7], s[6]};
  endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_rst;
    $rose(RST_N) |-> REG_RDATA == 8'h00 && !LEVEL_ALARM_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_off;
    !on && !frc && !$past(on) && !$past(frc) |-> !LEVEL_ALARM_OUT;
  endproperty
  a_off: assert property (p_off) else $error("alarm while off");
  property p_frc;
    frc && $past(frc) |-> LEVEL_ALARM_OUT == $past(s[0][2]);
  endproperty
  a_frc: assert property (p_frc) else $error("force value");
  property p_hit;
    SAMPLE.valid && !REG.wr && on && !frc && mag > {1'b0, s[3][3:0], s[2]} |=> LEVEL_ALARM_OUT;
  endproperty
  a_hit: assert property (p_hit) else $error("missed alarm");
endmodule
bind ldt_level_alarm ldt_level_alarm_sva u_sva (.CLK, .RST_N, .SAMPLE, .REG, .REG_RDATA,
  .LEVEL_ALARM_OUT);
`default_nettype wire

// ### sim/ldt_host_model.sv
// Purpose: host logic watching the alarm pin
// Assumes: pin sampled on the sample clock
// Notes: counts rising edges only; levels are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module ldt_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic alarm,
  output var int events
);
  logic last;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last <= 1'b0;
      events <= 0;
    end else begin
      last <= alarm;
      if (alarm && !last) begin
        events <= events + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/ldt_level_alarm_tb.sv
// Purpose: self-checking bench for the level alarm
// Assumes: strobe register port, one sample per call
// Notes: upper 0x164, lower 0x132, dwell 2
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH %0t got %h expected %h", $time, a, b); end end
module ldt_level_alarm_tb;
  import ldt_pkg::*;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  ldt_sample_type SAMPLE = '0;
  ldt_reg_req_type REG = '0;
  logic [7:0] REG_RDATA;
  logic LEVEL_ALARM_OUT;
  logic [7:0] q;
  int fail_count = 0;
  int n_compared = 0;
  int events;
  logic [11:0] sv [6] = '{12'h164, 12'hE9B, 12'h00A, 12'h132, 12'hFF6, 12'h00A};
  logic ex [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  ldt_level_alarm u_ldt_level_alarm (.CLK, .RST_N, .SAMPLE, .REG, .REG_RDATA, .LEVEL_ALARM_OUT);
  ldt_host_model u_ldt_host_model (.clk(CLK), .rst_n(RST_N), .alarm(LEVEL_ALARM_OUT), .events);
  initial begin
    forever #25 CLK = ~CLK;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK) REG <= '{1'b1, 1'b0, a, d};
    @(posedge CLK) REG <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK) REG <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge CLK) REG <= '0;
    @(negedge CLK) q = REG_RDATA;
  endtask
  task automatic smp(input logic [11:0] d);
    @(posedge CLK) SAMPLE <= '{1'b1, d};
    @(posedge CLK) SAMPLE <= '0;
    @(negedge CLK);
  endtask
  // force takes hold one edge after the write lands
  task automatic idle;
    @(posedge CLK);
    @(negedge CLK);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'h45 + 8'(i));
      `CHK(q, 8'h00);
    end
    wr(8'h47, 8'h64);
    wr(8'h48, 8'hF1);
    wr(8'h49, 8'h32);
    wr(8'h4A, 8'hF1);
    wr(8'h4B, 8'h02);
    wr(8'h4C, 8'hA5);
    rd(8'h4C);
    `CHK(q, 8'hA5);
    rd(8'h48);
    `CHK(q, 8'h01);
    rd(8'h4A);
    `CHK(q, 8'h01);
    wr(8'h4C, 8'h00);
    wr(8'h45, 8'h01);
    foreach (sv[i]) begin
      smp(sv[i]);
      `CHK(LEVEL_ALARM_OUT, ex[i]);
    end
    wr(8'h45, 8'h0D);
    idle();
    `CHK(LEVEL_ALARM_OUT, 1'b1);
    wr(8'h45, 8'h01);
    smp(12'hE9B);
    `CHK(LEVEL_ALARM_OUT, 1'b1);
    // forcing 0 while alarmed shows the override, not the comparison
    wr(8'h45, 8'h09);
    idle();
    `CHK(LEVEL_ALARM_OUT, 1'b0);
    wr(8'h45, 8'h01);
    idle();
    `CHK(LEVEL_ALARM_OUT, 1'b1);
    wr(8'h45, 8'h00);
    idle();
    `CHK(LEVEL_ALARM_OUT, 1'b0);
    smp(12'hE9B);
    `CHK(LEVEL_ALARM_OUT, 1'b0);
    `CHK(events, 4);
    complete_run();
  end
  // tests need about 72 cycles
  initial begin
    repeat (3000) @(posedge CLK);
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
